// *** design/ajr_pkg.sv ***
package ajr_pkg;
   // ************************************************************
   // timing and defaults
   // ************************************************************
   localparam int unsigned CLK_PERIOD_NS      = 10;
   localparam int unsigned TCK_HALF_NS        = 200;       // fixed-mode half period
   localparam int unsigned TCK_HALF_CYC       = (TCK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned RST_PULSE_NS       = 1000;      // reset pulse width driven by probe
   localparam int unsigned RST_PULSE_CYC      = (RST_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned TIMEOUT_CYC        = 4000;      // adaptive wait bound
   localparam logic        RST_POL_DEFAULT    = 1'b0;      // both resets active low
   localparam logic [31:0] DBG_STATUS_RESET   = 32'h0000_0000;

   // ************************************************************
   // controller registers (word byte addresses)
   // ************************************************************
   localparam logic [3:0]  REG_CTRL           = 4'h0;
   localparam logic [3:0]  REG_SHIFT          = 4'h4;
   localparam logic [3:0]  REG_TDO            = 4'h8;
   localparam logic [3:0]  REG_STATUS         = 4'hc;

   // ctrl fields
   localparam int unsigned CTRL_ADAPTIVE      = 0;
   localparam int unsigned CTRL_TO_DISABLE    = 1;
   localparam int unsigned CTRL_SRST_POL      = 2;
   localparam int unsigned CTRL_TRST_POL      = 3;
   localparam int unsigned CTRL_SRST_STRONG   = 4;
   localparam int unsigned CTRL_TRST_STRONG   = 5;
   localparam int unsigned CTRL_PULSE_SRST    = 6;
   localparam int unsigned CTRL_PULSE_TRST    = 7;
   localparam int unsigned CTRL_HALT_REQ      = 8;
   localparam int unsigned CTRL_CLR_TIMEOUT   = 9;
   localparam int unsigned CTRL_RESET_VALUE   = 0;
   // shift fields: bit0 tms, bit1 tdi; any write while idle starts a bit
   localparam int unsigned SHIFT_TMS          = 0;
   localparam int unsigned SHIFT_TDI          = 1;
   // status fields
   localparam int unsigned STAT_BUSY          = 0;
   localparam int unsigned STAT_TIMEOUT       = 1;
   localparam int unsigned STAT_HALT_ACK      = 2;
   localparam int unsigned STAT_RST_BUSY      = 3;

   // probe bit-cycle states
   typedef enum logic [1:0] {
      AJR_IDLE  = 2'b00,
      AJR_LOW   = 2'b01,
      AJR_HIGH  = 2'b11,
      AJR_DONE  = 2'b10
   } ajr_probe_e;
endpackage

// *** design/ajr_link_if.sv ***
`timescale 1ns/100ps
// link between probe and target; reset lines are open-drain style pins unless set to strong drive
interface ajr_link_if;
   logic tck;
   logic tms;
   logic tdi;
   logic tdo;
   logic return_clock;
   logic system_warm_reset_n_o;
   logic system_warm_reset_n_oe;
   logic tap_reset_n_o;
   logic tap_reset_n_oe;
   logic halt_request;
   logic halt_acknowledge;

   modport probe (
      output tck, tms, tdi, system_warm_reset_n_o, system_warm_reset_n_oe,
      output tap_reset_n_o, tap_reset_n_oe, halt_request,
      input  tdo, return_clock, halt_acknowledge
   );
   modport target (
      input  tck, tms, tdi, system_warm_reset_n_o, system_warm_reset_n_oe,
      input  tap_reset_n_o, tap_reset_n_oe, halt_request,
      output tdo, return_clock, halt_acknowledge
   );
endinterface

// *** design/ajr_target.sv ***
`timescale 1ns/100ps
// ************************************************************
// target end: synchroniser, tap capture and reset combining
// ************************************************************
module ajr_target
#(
   parameter int unsigned SHIFT_W = 32
)
(
   // clock and power-on reset
   input  wire logic               CLK_IN,
   input  wire logic               RST_N_IN,
   // other reset sources and polarity straps
   input  wire logic               BUTTON_RESET_N_IN,
   input  wire logic               WATCHDOG_RESET_IN,
   input  wire logic               SRST_ACTIVE_HIGH_IN,
   input  wire logic               TRST_ACTIVE_HIGH_IN,
   // link
   ajr_link_if.target              link,
   // user side
   input  wire logic               LEAVE_DEBUG_IN,
   output logic                    WARM_RESET_OUT,
   output logic                    IN_DEBUG_OUT,
   output logic [SHIFT_W-1:0]      SHIFT_DATA_OUT,
   output logic [SHIFT_W-1:0]      TMS_HIST_OUT,
   output logic                    TAP_RESET_SEEN_OUT
);
   typedef struct packed {
      logic [1:0]         tck_s;      // two-flop sync of tck
      logic               tck_d;      // last synced value for edge find
      logic [1:0]         tms_s;
      logic [1:0]         tdi_s;
      logic [1:0]         srst_s;
      logic [1:0]         trst_s;
      logic [1:0]         halt_s;
      logic [1:0]         btn_s;
      logic [1:0]         wdg_s;
      logic               rclk;
      logic               tdo;
      logic               in_debug;
      logic [SHIFT_W-1:0] shift;
      logic [SHIFT_W-1:0] tms_hist;
      logic               trst_seen;
   } ajr_tgt_s;

   ajr_tgt_s st_reg;
   ajr_tgt_s st_next;
   logic     test_clock_rise_enable;
   logic     test_clock_fall_enable;
   logic     srst_act;
   logic     trst_act;

   // ************************************************************
   // edge enables and reset decode
   // ************************************************************
   // edges come only from the second sync flop, so one clock each
   assign test_clock_rise_enable = st_reg.tck_s[1] & ~st_reg.tck_d;
   assign test_clock_fall_enable = ~st_reg.tck_s[1] & st_reg.tck_d;
   // sync chains carry active-high flags, so their cleared state is inactive
   assign srst_act = st_reg.srst_s[1];
   assign trst_act = st_reg.trst_s[1];

   // next state
   always_comb
   begin
      st_next        = st_reg;
      st_next.tck_s  = {st_reg.tck_s[0], link.tck};
      st_next.tck_d  = st_reg.tck_s[1];
      st_next.tms_s  = {st_reg.tms_s[0], link.tms};
      st_next.tdi_s  = {st_reg.tdi_s[0], link.tdi};
      // undriven line reads as pulled inactive; the strap turns the pin level
      // into an active flag ahead of the sync, so a strap change or a power-on
      // clear never shows a false reset while the chain refills
      st_next.srst_s = {st_reg.srst_s[0], (link.system_warm_reset_n_oe ?
                        link.system_warm_reset_n_o : ~SRST_ACTIVE_HIGH_IN)
                        ^ ~SRST_ACTIVE_HIGH_IN};
      st_next.trst_s = {st_reg.trst_s[0], (link.tap_reset_n_oe ?
                        link.tap_reset_n_o : ~TRST_ACTIVE_HIGH_IN)
                        ^ ~TRST_ACTIVE_HIGH_IN};
      st_next.halt_s = {st_reg.halt_s[0], link.halt_request};
      st_next.btn_s  = {st_reg.btn_s[0], ~BUTTON_RESET_N_IN};          // kept active high
      st_next.wdg_s  = {st_reg.wdg_s[0], WATCHDOG_RESET_IN};
      // return clock follows the last sync flop, only at edges
      if (test_clock_rise_enable | test_clock_fall_enable)
      begin
         st_next.rclk = st_reg.tck_s[1];
      end
      if (test_clock_rise_enable)
      begin
         st_next.shift    = {st_reg.tdi_s[1], st_reg.shift[SHIFT_W-1:1]};
         st_next.tms_hist = {st_reg.tms_hist[SHIFT_W-2:0], st_reg.tms_s[1]};
      end
      if (test_clock_fall_enable)
      begin
         st_next.tdo = st_reg.shift[0];
      end
      // halt request enters debug state, user logic releases it
      if (st_reg.halt_s[1])
      begin
         st_next.in_debug = 1'b1;
      end
      else if (LEAVE_DEBUG_IN)
      begin
         st_next.in_debug = 1'b0;
      end
      // tap reset clears tap-side state only; system reset never does
      if (trst_act)
      begin
         st_next.shift     = '0;
         st_next.tms_hist  = '0;
         st_next.tdo       = 1'b0;
         st_next.trst_seen = 1'b1;
      end
   end

   // state register, cleared only by power-on reset
   always_ff @(posedge CLK_IN or negedge RST_N_IN)
   begin
      if (!RST_N_IN)
      begin
         st_reg <= '0;
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   // ************************************************************
   // outputs
   // ************************************************************
   // warm reset gathers button, watchdog and probe; power-on via RST_N_IN
   assign WARM_RESET_OUT     = ~RST_N_IN | st_reg.btn_s[1] | st_reg.wdg_s[1]
                               | srst_act;
   assign IN_DEBUG_OUT       = st_reg.in_debug;
   assign SHIFT_DATA_OUT     = st_reg.shift;
   assign TMS_HIST_OUT       = st_reg.tms_hist;
   assign TAP_RESET_SEEN_OUT = st_reg.trst_seen;
   assign link.return_clock     = st_reg.rclk;
   assign link.tdo              = st_reg.tdo;
   assign link.halt_acknowledge = st_reg.in_debug;
endmodule

// *** design/ajr_probe.sv ***
`timescale 1ns/100ps
// ************************************************************
// probe end: avalon slave, bit engine, reset drivers
// ************************************************************
module ajr_probe
#(
   parameter int unsigned TIMEOUT_CYCLES = ajr_pkg::TIMEOUT_CYC
)
(
   // clock and reset
   input  wire logic        CLK_IN,
   input  wire logic        RST_N_IN,
   // avalon-mm slave
   input  wire logic [3:0]  AVS_ADDRESS_IN,
   input  wire logic        AVS_READ_IN,
   input  wire logic        AVS_WRITE_IN,
   input  wire logic [31:0] AVS_WRITEDATA_IN,
   output logic [31:0]      AVS_READDATA_OUT,
   output logic             AVS_WAITREQUEST_OUT,
   // link
   ajr_link_if.probe        link
);
   typedef ajr_pkg::ajr_probe_e ajr_probe_e_t;
   typedef struct packed {
      logic [9:0]          ctrl;
      logic                tms;
      logic                tdi;
      logic                tdo_bit;
      logic                timeout;
      ajr_probe_e_t        ph;
      logic [15:0]         cnt;
      logic [15:0]         rst_cnt;
      logic                drv_srst;
      logic                drv_trst;
      logic                tck;
      logic [1:0]          rclk_s;
      logic [1:0]          tdo_s;
      logic [1:0]          ack_s;
      logic                rd_done;
      logic [31:0]         rdata;
   } ajr_prb_s;

   ajr_prb_s st_reg;
   ajr_prb_s st_next;
   logic     adaptive;
   logic     busy;
   logic     wait_ok;
   logic     to_hit;

   assign adaptive = st_reg.ctrl[ajr_pkg::CTRL_ADAPTIVE];
   assign busy     = st_reg.ph != ajr_pkg::AJR_IDLE;
   // adaptive: wait until the synced return clock matches tck
   assign wait_ok  = adaptive ? (st_reg.rclk_s[1] == st_reg.tck)
                              : (st_reg.cnt >= 16'(ajr_pkg::TCK_HALF_CYC - 1));
   // timeout is not scaled to the pace; may be turned off
   assign to_hit   = adaptive & ~st_reg.ctrl[ajr_pkg::CTRL_TO_DISABLE]
                     & (st_reg.cnt >= 16'(TIMEOUT_CYCLES));

   // next state
   always_comb
   begin
      st_next         = st_reg;
      st_next.rclk_s  = {st_reg.rclk_s[0], link.return_clock};
      st_next.tdo_s   = {st_reg.tdo_s[0], link.tdo};
      st_next.ack_s   = {st_reg.ack_s[0], link.halt_acknowledge};
      st_next.rd_done = 1'b0;
      st_next.ctrl[ajr_pkg::CTRL_CLR_TIMEOUT] = 1'b0;
      // register reads answer one cycle after the request
      if (AVS_READ_IN & ~st_reg.rd_done)
      begin
         st_next.rd_done = 1'b1;
         case (AVS_ADDRESS_IN)
            ajr_pkg::REG_CTRL:   st_next.rdata = {22'h00_0000, st_reg.ctrl};
            ajr_pkg::REG_TDO:    st_next.rdata = {31'h0000_0000, st_reg.tdo_bit};
            ajr_pkg::REG_STATUS: st_next.rdata = {28'h000_0000,
                                   (st_reg.rst_cnt != 16'h0000), st_reg.ack_s[1],
                                   st_reg.timeout, busy};
            default:             st_next.rdata = 32'h0000_0000;
         endcase
      end
      // reset pulse countdown runs first so that a new pulse request overrides it
      if (st_reg.rst_cnt != 16'h0000)
      begin
         st_next.rst_cnt = st_reg.rst_cnt - 16'h0001;
      end
      // drive drops with the last count, so the pulse lasts exactly the count
      if (st_reg.rst_cnt <= 16'h0001)
      begin
         st_next.drv_srst = 1'b0;
         st_next.drv_trst = 1'b0;
      end
      // writes complete at once
      if (AVS_WRITE_IN & (AVS_ADDRESS_IN == ajr_pkg::REG_CTRL))
      begin
         st_next.ctrl = AVS_WRITEDATA_IN[9:0];
         if (AVS_WRITEDATA_IN[ajr_pkg::CTRL_PULSE_SRST]
             | AVS_WRITEDATA_IN[ajr_pkg::CTRL_PULSE_TRST])
         begin
            st_next.rst_cnt  = 16'(ajr_pkg::RST_PULSE_CYC);
            st_next.drv_srst = AVS_WRITEDATA_IN[ajr_pkg::CTRL_PULSE_SRST];
            st_next.drv_trst = AVS_WRITEDATA_IN[ajr_pkg::CTRL_PULSE_TRST];
         end
         if (AVS_WRITEDATA_IN[ajr_pkg::CTRL_CLR_TIMEOUT])
         begin
            st_next.timeout = 1'b0;
         end
      end
      else if (AVS_WRITE_IN & (AVS_ADDRESS_IN == ajr_pkg::REG_SHIFT) & ~busy)
      begin
         st_next.tms = AVS_WRITEDATA_IN[ajr_pkg::SHIFT_TMS];
         st_next.tdi = AVS_WRITEDATA_IN[ajr_pkg::SHIFT_TDI];
         st_next.ph  = ajr_pkg::AJR_LOW;
         st_next.tck = 1'b0;
         st_next.cnt = 16'h0000;
      end
      // one tck cycle: low half, then high half
      case (st_reg.ph)
         ajr_pkg::AJR_IDLE: ;
         ajr_pkg::AJR_LOW, ajr_pkg::AJR_HIGH:
         begin
            st_next.cnt = st_reg.cnt + 16'h0001;
            if (to_hit)
            begin
               st_next.timeout = 1'b1;
               st_next.ph      = ajr_pkg::AJR_IDLE;
               st_next.tck     = 1'b0;
            end
            else if (wait_ok)
            begin
               st_next.cnt = 16'h0000;
               if (st_reg.ph == ajr_pkg::AJR_LOW)
               begin
                  st_next.tck = 1'b1;
                  st_next.ph  = ajr_pkg::AJR_HIGH;
               end
               else
               begin
                  // tdo taken once the return clock is back high, or once the high half is counted in fixed pace
                  st_next.tdo_bit = st_reg.tdo_s[1];
                  st_next.tck     = 1'b0;
                  st_next.ph      = ajr_pkg::AJR_DONE;
               end
            end
         end
         ajr_pkg::AJR_DONE:
         begin
            // fixed pace has nothing to wait for; the next low half is counted
            if (!adaptive | wait_ok)
            begin
               st_next.ph = ajr_pkg::AJR_IDLE;
            end
         end
         default: st_next.ph = ajr_pkg::AJR_IDLE;
      endcase
   end

   always_ff @(posedge CLK_IN or negedge RST_N_IN)
   begin
      if (!RST_N_IN)
      begin
         st_reg <= '0;
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   // ************************************************************
   // outputs
   // ************************************************************
   assign AVS_WAITREQUEST_OUT = AVS_READ_IN & ~st_reg.rd_done;
   assign AVS_READDATA_OUT    = st_reg.rdata;
   assign link.tck            = st_reg.tck;
   assign link.tms            = st_reg.tms;
   assign link.tdi            = st_reg.tdi;
   assign link.halt_request   = st_reg.ctrl[ajr_pkg::CTRL_HALT_REQ];
   // active level from polarity bit; weak drive leaves line released
   assign link.system_warm_reset_n_o  = st_reg.drv_srst ~^ st_reg.ctrl[ajr_pkg::CTRL_SRST_POL];
   assign link.system_warm_reset_n_oe = st_reg.drv_srst
                                        | st_reg.ctrl[ajr_pkg::CTRL_SRST_STRONG];
   assign link.tap_reset_n_o          = st_reg.drv_trst ~^ st_reg.ctrl[ajr_pkg::CTRL_TRST_POL];
   assign link.tap_reset_n_oe         = st_reg.drv_trst
                                        | st_reg.ctrl[ajr_pkg::CTRL_TRST_STRONG];
endmodule

// *** test/ajr_link_asserts.sv ***
`timescale 1ns/100ps
// ************************************************************
// link checker: both ends seen from the wire
// ************************************************************
module ajr_link_asserts
(
   // clock and reset
   input wire logic CLK_IN,
   input wire logic RST_N_IN,
   // link
   input wire logic tck,
   input wire logic tms,
   input wire logic tdi,
   input wire logic tdo,
   input wire logic return_clock,
   input wire logic halt_request,
   input wire logic halt_acknowledge
);
   default clocking @(posedge CLK_IN);
   endclocking
   default disable iff (!RST_N_IN);
   // request held long enough to pass the synchroniser
   sequence s_req_held;
      halt_request [*4];
   endsequence
   sequence s_tck_up;
      $rose(tck);
   endsequence
   // return clock trails tck by the synchroniser depth plus its own register
   a_rclk_rise_lag: assert property (s_tck_up |-> ##[2:4] return_clock)
      else $error("return clock late after tck rise");
   a_rclk_fall_lag: assert property ($fell(tck) |-> ##[2:4] !return_clock)
      else $error("return clock late after tck fall");
   a_rclk_edge_only: assert property ($changed(return_clock) |-> return_clock == tck)
      else $error("return clock moved without tck edge");
   a_tdo_on_fall: assert property ($changed(tdo) |-> !tck && !$past(tck))
      else $error("tdo moved outside tck low phase");
   a_tms_tdi_hold: assert property (tck |-> $stable(tms) && $stable(tdi))
      else $error("tms or tdi moved while tck high");
   a_rise_paced: assert property (s_tck_up |-> !$past(return_clock))
      else $error("tck rose before return clock fell");
   a_fall_paced: assert property ($fell(tck) |-> $past(return_clock))
      else $error("tck fell before return clock rose");
   a_ack_follows: assert property ($rose(halt_request) |-> ##[1:6] halt_acknowledge)
      else $error("no halt acknowledge after request");
   a_ack_held: assert property (s_req_held ##0 halt_acknowledge |=> halt_acknowledge)
      else $error("halt acknowledge dropped while requested");
   a_ack_cause: assert property ($rose(halt_acknowledge) |-> $past(halt_request))
      else $error("halt acknowledge without request");
endmodule

// *** test/ajr_tb_top.sv ***
`timescale 1ns/100ps
// ************************************************************
// bench: joined probe and target, plus a probe on a dead link
// ************************************************************
module adaptive_jtag_reset_control_tb_top;
   localparam int TO_CYC = 200;   // short timeout keeps the dead-link case brief
   localparam int HALF   = ajr_pkg::TCK_HALF_CYC;
   localparam int PULSE  = ajr_pkg::RST_PULSE_CYC;
   localparam logic [3:0] CTRL = ajr_pkg::REG_CTRL;
   localparam logic [3:0] SHFT = ajr_pkg::REG_SHIFT;
   localparam logic [3:0] TDOR = ajr_pkg::REG_TDO;
   localparam logic [3:0] STAT = ajr_pkg::REG_STATUS;
   typedef struct packed {logic [31:0] ctrl; logic [31:0] tdi; logic [31:0] tms;} ajr_row_s;
   // ordinary cases: pacing mode and the streams shifted in it
   localparam ajr_row_s ROWS [3] = '{
      '{32'h0000_0000, 32'hA5C3_0F96, 32'h0000_0005},
      '{32'h0000_0001, 32'h1234_5678, 32'h8000_0002},
      '{32'h0000_0003, 32'hFFFF_0001, 32'h0000_0000}};
   logic        clk, rst_n, rst_b_n, button_n, watchdog, srst_hi, trst_hi, leave_dbg;
   logic        warm_rst, in_dbg, tap_seen, pol, ln;
   logic [3:0]  av_addr [2];
   logic        av_rd [2], av_wr [2], av_wait [2];
   logic [31:0] av_wdata [2], av_rdata [2];
   logic [31:0] shift_data, tms_hist, rq, sr, th;
   int          n_fail = 0, cmp_count = 0, hi_cnt = 0, hi_w = 0, cnt, k, r, b;
   int          pl_cnt = 0, pl_w = 0;
   ajr_link_if link_a ();
   ajr_link_if link_b ();
   // reset line picked by the polarity sweep
   wire logic   ln_oe = ln ? link_a.tap_reset_n_oe : link_a.system_warm_reset_n_oe;
   wire logic   ln_o  = ln ? link_a.tap_reset_n_o : link_a.system_warm_reset_n_o;
   // dead far end never returns the clock; tdo toggles so no stale level passes
   assign link_b.return_clock     = 1'b0;
   assign link_b.tdo              = ~link_b.tck;
   assign link_b.halt_acknowledge = 1'b0;
   ajr_target u_ajr_target (.CLK_IN(clk), .RST_N_IN(rst_n), .BUTTON_RESET_N_IN(button_n),
      .WATCHDOG_RESET_IN(watchdog), .SRST_ACTIVE_HIGH_IN(srst_hi), .TRST_ACTIVE_HIGH_IN(trst_hi),
      .link(link_a.target), .LEAVE_DEBUG_IN(leave_dbg), .WARM_RESET_OUT(warm_rst),
      .IN_DEBUG_OUT(in_dbg), .SHIFT_DATA_OUT(shift_data), .TMS_HIST_OUT(tms_hist),
      .TAP_RESET_SEEN_OUT(tap_seen));
   ajr_probe #(.TIMEOUT_CYCLES(TO_CYC)) u_ajr_probe (.CLK_IN(clk), .RST_N_IN(rst_n),
      .AVS_ADDRESS_IN(av_addr[0]), .AVS_READ_IN(av_rd[0]), .AVS_WRITE_IN(av_wr[0]),
      .AVS_WRITEDATA_IN(av_wdata[0]), .AVS_READDATA_OUT(av_rdata[0]),
      .AVS_WAITREQUEST_OUT(av_wait[0]), .link(link_a.probe));
   ajr_probe #(.TIMEOUT_CYCLES(TO_CYC)) u_ajr_probe_b (.CLK_IN(clk), .RST_N_IN(rst_b_n),
      .AVS_ADDRESS_IN(av_addr[1]), .AVS_READ_IN(av_rd[1]), .AVS_WRITE_IN(av_wr[1]),
      .AVS_WRITEDATA_IN(av_wdata[1]), .AVS_READDATA_OUT(av_rdata[1]),
      .AVS_WAITREQUEST_OUT(av_wait[1]), .link(link_b.probe));
   ajr_link_asserts u_chk (.CLK_IN(clk), .RST_N_IN(rst_n), .tck(link_a.tck), .tms(link_a.tms),
      .tdi(link_a.tdi), .tdo(link_a.tdo), .return_clock(link_a.return_clock),
      .halt_request(link_a.halt_request), .halt_acknowledge(link_a.halt_acknowledge));
   // ************************************************************
   // clock and tck high-phase monitor
   // ************************************************************
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk)
   begin
      hi_cnt <= link_a.tck ? hi_cnt + 1 : 0;
      if (!link_a.tck && hi_cnt != 0)
         hi_w <= hi_cnt;
      // active width of the reset line picked by the sweep, edge by edge
      pl_cnt <= (ln_oe === 1'b1 && ln_o === pol) ? pl_cnt + 1 : 0;
      if (pl_cnt != 0 && !(ln_oe === 1'b1 && ln_o === pol))
         pl_w <= pl_cnt;
   end
   // ************************************************************
   // tasks
   // ************************************************************
   task chk1(input string what, input logic exp, input logic got);
      cmp_count++;
      if (got !== exp)
      begin
         n_fail++;
         $display("ERROR %s expected %b seen %b", what, exp, got);
      end
   endtask
   task chk32(input string what, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp)
      begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask
   task tally_and_finish();
      $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task hang(input string what);
      n_fail++;
      $display("ERROR %s expected answer seen timeout", what);
      tally_and_finish();
   endtask
   // one avalon transfer; waitrequest is sampled where the edge will see it
   task bus(input int p, input logic [3:0] a, input logic rd, input logic [31:0] d);
      int   n;
      logic w;
      av_addr[p] <= a;
      av_rd[p] <= rd;
      av_wr[p] <= ~rd;
      av_wdata[p] <= d;
      for (n = 0; n < 20; n++)
      begin
         @(negedge clk);
         w = av_wait[p];
         rq = av_rdata[p];
         @(posedge clk);
         if (w === 1'b0)
            break;
      end
      if (n == 20)
         hang("bus");
      av_rd[p] <= 1'b0;
      av_wr[p] <= 1'b0;
      @(posedge clk);
   endtask
   task wait_idle();
      int n;
      for (n = 0; n < 300; n++)
      begin
         bus(0, STAT, 1'b1, 32'h0000_0000);
         if (rq[ajr_pkg::STAT_BUSY] === 1'b0)
            break;
      end
      if (n == 300)
         hang("busy");
   endtask
   // ************************************************************
   // main sequence
   // ************************************************************
   initial
   begin
      rst_n = 1'b0;
      rst_b_n = 1'b0;
      {button_n, watchdog, srst_hi, trst_hi, leave_dbg, pol, ln} = 7'h40;
      av_rd = '{2{1'b0}};
      av_wr = '{2{1'b0}};
      av_addr = '{2{4'h0}};
      av_wdata = '{2{32'h0000_0000}};
      sr = 32'h0000_0000;
      th = 32'h0000_0000;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      rst_b_n <= 1'b1;
      @(posedge clk);
      bus(0, STAT, 1'b1, 32'h0000_0000);
      chk32("status at reset", ajr_pkg::DBG_STATUS_RESET, rq);
      bus(0, 4'h2, 1'b1, 32'h0000_0000);
      chk32("unmapped read", 32'h0000_0000, rq);
      // shift each row bit by bit; tdi enters at the top, tdo shows the bottom
      for (r = 0; r < 3; r++)
      begin
         bus(0, CTRL, 1'b0, ROWS[r].ctrl);
         for (b = 0; b < 33; b++)
         begin
            bus(0, SHFT, 1'b0, {29'h0, 1'b1, ROWS[r].tdi[b % 32], ROWS[r].tms[b % 32]});
            wait_idle();
            // the probe keeps the level that stood before this bit's fall
            bus(0, TDOR, 1'b1, 32'h0000_0000);
            chk1("tdo register", sr[0], rq[0]);
            sr = {ROWS[r].tdi[b % 32], sr[31:1]};
            th = {th[30:0], ROWS[r].tms[b % 32]};
            chk32("shift data", sr, shift_data);
            chk32("tms history", th, tms_hist);
            chk1("tdo after fall", sr[0], link_a.tdo);
         end
         chk1("tck pacing", 1'b1, ROWS[r].ctrl[0] ? hi_w < HALF : hi_w == HALF);
      end
      // polarity sweep: weak drive active low, then strong drive active high
      for (k = 0; k < 4; k++)
      begin
         pol = k[1];
         ln = k[0];
         srst_hi <= k[1];
         trst_hi <= k[1];
         bus(0, CTRL, 1'b0, (k[1] ? 32'h0000_003C : 32'h0000_0000) | (32'h0000_0040 << k[0]));
         cnt = 0;
         for (r = 0; r < 400; r++)
         begin
            @(negedge clk);
            if (ln_oe === 1'b1 && ln_o === pol)
               cnt++;
            else if (cnt != 0)
               break;
            if (cnt == PULSE / 2)
               chk1("warm reset in pulse", ~k[0], warm_rst);
         end
         repeat (2) @(posedge clk);
         chk32("pulse width", 32'(PULSE), 32'(pl_w));
         chk1("idle drive", pol, ln_oe);
         chk1("tap reset seen", k != 0, tap_seen);
         chk32("shift after pulse", k == 0 ? sr : 32'h0000_0000, shift_data);
      end
      // button, then watchdog, each alone raises the warm reset
      for (k = 0; k < 2; k++)
      begin
         button_n <= k[0];
         watchdog <= k[0];
         repeat (4) @(posedge clk);
         chk1("source reset", 1'b1, warm_rst);
         button_n <= 1'b1;
         watchdog <= 1'b0;
         repeat (4) @(posedge clk);
         chk1("source released", 1'b0, warm_rst);
      end
      // leaving is asked for early and must wait for the request to drop
      leave_dbg <= 1'b1;
      bus(0, CTRL, 1'b0, 32'h0000_0100);
      repeat (20) @(posedge clk);
      chk1("in debug", 1'b1, in_dbg);
      bus(0, STAT, 1'b1, 32'h0000_0000);
      chk1("status halt ack", 1'b1, rq[ajr_pkg::STAT_HALT_ACK]);
      bus(0, CTRL, 1'b0, 32'h0000_0000);
      repeat (20) @(posedge clk);
      chk1("left debug", 1'b0, in_dbg);
      chk1("ack released", 1'b0, link_a.halt_acknowledge);
      // dead link: timeout cuts the wait; a reset then timeouts off
      bus(1, CTRL, 1'b0, 32'h0000_0001);
      bus(1, SHFT, 1'b0, 32'h0000_0004);
      repeat (TO_CYC + 20) @(posedge clk);
      bus(1, STAT, 1'b1, 32'h0000_0000);
      chk1("timeout flag", 1'b1, rq[ajr_pkg::STAT_TIMEOUT]);
      bus(1, CTRL, 1'b0, 32'h0000_0201);
      bus(1, STAT, 1'b1, 32'h0000_0000);
      chk1("timeout cleared", 1'b0, rq[ajr_pkg::STAT_TIMEOUT]);
      rst_b_n <= 1'b0;
      @(posedge clk);
      rst_b_n <= 1'b1;
      @(posedge clk);
      bus(1, CTRL, 1'b0, 32'h0000_0003);
      bus(1, SHFT, 1'b0, 32'h0000_0004);
      repeat (2 * TO_CYC) @(posedge clk);
      bus(1, STAT, 1'b1, 32'h0000_0000);
      chk32("waits without timeout", 32'h0000_0001, rq & 32'h0000_0003);
      tally_and_finish();
   end
endmodule
